// ===== tb/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
    import io_port_pkg::*;
(
    input  wire logic [NPORT-1:0][PW-1:0] pin_out_i,  // block outputs
    input  wire logic [NPORT-1:0][PW-1:0] pin_oe_n_i, // low drives
    input  wire logic [NPORT-1:0][PW-1:0] ext_val_i,  // far side level
    output logic      [NPORT-1:0][PW-1:0] pin_in_o    // wire level
);
    // External logic always drives undriven pins, so a pin that the
    // block drives by mistake shows up as a changed read-back.
    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
            pin_in_o[p] = (pin_out_i[p] & ~pin_oe_n_i[p])
                        | (ext_val_i[p] & pin_oe_n_i[p]);
    end
endmodule

// ===== tb/io_port_block_tb_top.sv
`timescale 1ns/1ps
module io_port_block_tb_top
    import io_port_pkg::*;
;
    logic                     clk_i, resetn_i, rvalid_o, addr_strobe_i;
    acc_t                     acc_i;
    logic [PW-1:0]            rdata_o, mcell_a_i, mcell_b_i;
    logic [PW-1:0]            map_reg_i, mcu_data_i;
    logic [15:0]              addr_i;
    logic [NPORT-1:0][PW-1:0] pin_in_i, pin_out_o, pin_oe_n_o;
    logic [NPORT-1:0][PW-1:0] drive_sel_o, logic_in_o, pt_oe_i;
    logic [NPORT-1:0][PW-1:0] pt_def_cfg_i, pld_out_cfg_i, ext_val;
    logic [2:0][1:0]          imc_mode_i;
    logic [2:0]               imc_pt_clk_i, imc_use_pt_i, ext_sel_i;
    logic [2:0]               scan_en_i;
    logic [1:0]               bus_type_i;
    logic                     data_port_cfg_i, psel_a_i, psel_b_i;
    logic                     mcu_rd_i;
    logic [3:0]               scan_out_i, scan_oe_i;
    int                       n_errors, total_checks;

    io_port_block dut (.clk_i, .resetn_i, .acc_i, .rdata_o, .rvalid_o,
        .addr_i, .addr_strobe_i, .pin_in_i, .pin_out_o, .pin_oe_n_o,
        .drive_sel_o, .logic_in_o, .mcell_a_i, .mcell_b_i, .ext_sel_i,
        .pt_oe_i, .pt_def_cfg_i, .pld_out_cfg_i, .imc_mode_i,
        .imc_pt_clk_i, .imc_use_pt_i, .bus_type_i, .data_port_cfg_i,
        .map_reg_i, .psel_a_i, .psel_b_i, .mcu_rd_i, .mcu_data_i,
        .scan_en_i, .scan_out_i, .scan_oe_i);

    far_side_model far (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
        .ext_val_i(ext_val), .pin_in_o(pin_in_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    // One access cycle; the register is taken at the next edge.
    task automatic acc(input int w, input logic [2:0] p,
                       input logic [2:0] k, input logic [7:0] d);
        step(1);
        acc_i = '{w[0], ~w[0], p, k, d};
        step(1);
        acc_i = '0;
    endtask

    task automatic rd(input logic [2:0] p, input logic [2:0] k,
                      input logic [7:0] exp);
        acc(0, p, k, 8'h00);
        chk({7'h00, rvalid_o}, 8'h01);
        chk(rdata_o, exp);
    endtask

    initial
    begin
        step(4000);
        n_errors++;
        stop_test();
    end

    initial
    begin
        n_errors = 0; total_checks = 0; resetn_i = 1'b0; acc_i = '0;
        addr_i = 16'h0000; addr_strobe_i = 1'b0; mcell_a_i = 8'h00;
        mcell_b_i = 8'h00; ext_sel_i = 3'h0; pt_oe_i = '0;
        pt_def_cfg_i = '0; pld_out_cfg_i = '0; ext_val = '0;
        imc_mode_i = '0; imc_pt_clk_i = 3'h0; imc_use_pt_i = 3'h0;
        bus_type_i = BUS_MUX; data_port_cfg_i = 1'b0; map_reg_i = 8'h00;
        psel_a_i = 1'b0; psel_b_i = 1'b0; mcu_rd_i = 1'b0;
        mcu_data_i = 8'h5A; scan_en_i = 3'h0; scan_out_i = 4'h0;
        scan_oe_i = 4'h0;
        step(3);
        resetn_i = 1'b1;
        chk(pin_oe_n_o[PORT_E], 8'hFF);
        for (int p = 0; p < NPORT; p++)
        begin
            rd(p[2:0], K_DIR, 8'h00);
            rd(p[2:0], K_CTRL, 8'h00);
            rd(p[2:0], K_DRV, 8'h00);
        end
        acc(1, PORT_A, K_DOUT, 8'hA5);
        acc(1, PORT_A, K_DIR, 8'h0F);
        acc(1, PORT_A, K_DRV, 8'h81);
        ext_val[PORT_A] = 8'h3C;
        step(2);
        chk(pin_oe_n_o[PORT_A], 8'hF0);
        chk(pin_out_o[PORT_A] & 8'h0F, 8'h05);
        chk(drive_sel_o[PORT_A], 8'h81);
        rd(PORT_A, K_DOUT, 8'hA5);
        rd(PORT_A, K_DIN, 8'h35);
        acc(1, PORT_A, K_CTRL, 8'hFF);
        rd(PORT_A, K_CTRL, 8'h00);
        rd(3'h7, K_DIR, 8'h00);
        acc(1, PORT_D, K_DIR, 8'hFF);
        rd(PORT_D, K_DIR, 8'h0F);
        acc(1, PORT_D, K_DOUT, 8'hF6);
        step(2);
        chk(pin_out_o[PORT_D], 8'h06);
        pt_def_cfg_i[PORT_B] = 8'h80;
        pt_oe_i[PORT_B] = 8'hC0;
        step(2);
        chk(pin_oe_n_o[PORT_B], 8'h7F);
        // Boot order kept: address pins are set up before use.
        addr_i = 16'hB37C;
        addr_strobe_i = 1'b1;
        step(1);
        addr_strobe_i = 1'b0;
        addr_i = 16'h0000;
        acc(1, PORT_E, K_DOUT, 8'h11);
        acc(1, PORT_E, K_DIR, 8'hFF);
        step(2);
        chk(pin_out_o[PORT_E], 8'h11);
        acc(1, PORT_E, K_CTRL, 8'hFF);
        acc(1, PORT_G, K_CTRL, 8'hFF);
        acc(1, PORT_G, K_DIR, 8'hFF);
        step(2);
        chk(pin_out_o[PORT_E], 8'h7C);
        rd(PORT_E, K_CTRL, 8'hFF);
        for (int b = 0; b < 3; b++)
        begin
            bus_type_i = b[1:0];
            step(2);
            chk(pin_out_o[PORT_G], b == 2 ? 8'hB3 : 8'h7C);
            chk(pin_out_o[PORT_E], b == 0 ? 8'h7C : 8'h11);
        end
        bus_type_i = BUS_MUX;
        acc(1, PORT_G, K_DOUT, 8'h96);
        acc(1, PORT_G, K_CTRL, 8'h00);
        step(2);
        chk(pin_out_o[PORT_G], 8'h96);
        map_reg_i = 8'h80;
        step(2);
        chk(pin_oe_n_o[PORT_F], 8'hFF);
        for (int i = 0; i < 2; i++)
        begin
            psel_a_i = (i == 0);
            psel_b_i = (i == 1);
            step(2);
            chk(pin_oe_n_o[PORT_F], 8'h00);
            chk(pin_out_o[PORT_F], 8'h5A);
        end
        psel_b_i = 1'b0;
        map_reg_i = 8'h00;
        data_port_cfg_i = 1'b1;
        acc(1, PORT_F, K_DIR, 8'hFF);
        step(2);
        chk(pin_oe_n_o[PORT_F], 8'hFF);
        mcu_rd_i = 1'b1;
        step(2);
        chk(pin_out_o[PORT_F], 8'h5A);
        chk(pin_oe_n_o[PORT_F], 8'h00);
        mcu_rd_i = 1'b0;
        data_port_cfg_i = 1'b0;
        pld_out_cfg_i[PORT_A] = 8'hFF;
        pld_out_cfg_i[PORT_B] = 8'hFF;
        pld_out_cfg_i[PORT_C] = 8'h07;
        mcell_a_i = 8'hC3;
        mcell_b_i = 8'h96;
        ext_sel_i = 3'h5;
        acc(1, PORT_C, K_DIR, 8'h07);
        step(2);
        chk(pin_out_o[PORT_A] & 8'h0F, 8'h03);
        chk(pin_out_o[PORT_B] & 8'h80, 8'h80);
        chk(pin_out_o[PORT_C] & 8'h07, 8'h05);
        chk(pin_oe_n_o[PORT_A], 8'hF0);
        scan_out_i = 4'hA;
        scan_oe_i = 4'h5;
        for (int i = 0; i < 3; i++)
        begin
            scan_en_i = 3'h1 << i;
            step(2);
            chk(pin_out_o[PORT_E] & 8'h05, 8'h00);
            chk(pin_oe_n_o[PORT_E] & 8'h0F, 8'h0A);
        end
        scan_en_i = 3'h0;
        // Port B inputs keep their direction bits clear.
        ext_val[PORT_B] = 8'h5A;
        imc_mode_i[1] = IC_DIRECT;
        step(3);
        chk(logic_in_o[PORT_B] & 8'h7F, 8'h5A);
        imc_mode_i[1] = IC_LATCH;
        addr_strobe_i = 1'b1;
        step(2);
        addr_strobe_i = 1'b0;
        ext_val[PORT_B] = 8'h21;
        step(3);
        chk(logic_in_o[PORT_B] & 8'h7F, 8'h5A);
        imc_mode_i[1] = IC_REG;
        imc_use_pt_i[1] = 1'b1;
        imc_pt_clk_i[1] = 1'b1;
        step(2);
        imc_pt_clk_i[1] = 1'b0;
        step(3);
        chk(logic_in_o[PORT_B] & 8'h7F, 8'h21);
        rd(PORT_B, K_ICELL, 8'hA1);
        stop_test();
    end
endmodule

// ===== verilog/input_latch_cell.sv
`timescale 1ns/1ps
module input_latch_cell
    import io_port_pkg::*;
(
    input  wire logic          clk_i,    // system clock
    input  wire logic          resetn_i, // synchronous reset, active low
    input  wire logic [1:0]    mode_i,   // direct, latch or register
    input  wire logic          strobe_i, // address latch strobe
    input  wire logic          pt_clk_i, // product term clock
    input  wire logic          use_pt_i, // clock from product term
    input  wire logic [PW-1:0] din_i,    // pin levels
    output logic      [PW-1:0] q_o       // cell outputs
);

    logic          src;
    logic          src_d_reg;
    logic [PW-1:0] hold_reg;

    assign src = use_pt_i ? pt_clk_i : strobe_i;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            src_d_reg <= 1'b0;
        else
            src_d_reg <= src;
    end

    // latch follows while open, register takes rising edge
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            hold_reg <= REG_RST;
        else if (mode_i == IC_LATCH && src)
            hold_reg <= din_i;
        else if (mode_i == IC_REG && src && !src_d_reg)
            hold_reg <= din_i;
    end

    // The open latch is transparent so its output does not lag a cycle.
    assign q_o = (mode_i == IC_DIRECT) ? din_i :
                 (mode_i == IC_LATCH && src) ? din_i : hold_reg;

endmodule

// ===== verilog/io_port_block.sv
`timescale 1ns/1ps
module io_port_block
    import io_port_pkg::*;
(
    input  wire logic                      clk_i,          // 10 MHz clock
    input  wire logic                      resetn_i,       // sync reset
    input  wire acc_t                      acc_i,          // register access
    output logic      [PW-1:0]             rdata_o,        // read data
    output logic                           rvalid_o,       // read data valid
    input  wire logic [15:0]               addr_i,         // MCU address
    input  wire logic                      addr_strobe_i,  // address strobe
    input  wire logic [NPORT-1:0][PW-1:0]  pin_in_i,       // pin levels
    output logic      [NPORT-1:0][PW-1:0]  pin_out_o,      // pin outputs
    output logic      [NPORT-1:0][PW-1:0]  pin_oe_n_o,     // low drives
    output logic      [NPORT-1:0][PW-1:0]  drive_sel_o,    // drive select
    output logic      [NPORT-1:0][PW-1:0]  logic_in_o,     // logic inputs
    input  wire logic [PW-1:0]             mcell_a_i,      // group A cells
    input  wire logic [PW-1:0]             mcell_b_i,      // group B cells
    input  wire logic [2:0]                ext_sel_i,      // ext selects
    input  wire logic [NPORT-1:0][PW-1:0]  pt_oe_i,        // enable terms
    input  wire logic [NPORT-1:0][PW-1:0]  pt_def_cfg_i,   // term defined
    input  wire logic [NPORT-1:0][PW-1:0]  pld_out_cfg_i,  // logic output
    input  wire logic [2:0][1:0]           imc_mode_i,     // cell modes
    input  wire logic [2:0]                imc_pt_clk_i,   // cell term clk
    input  wire logic [2:0]                imc_use_pt_i,   // use term clk
    input  wire logic [1:0]                bus_type_i,     // MCU bus type
    input  wire logic                      data_port_cfg_i, // F data port
    input  wire logic [PW-1:0]             map_reg_i,      // mapping reg
    input  wire logic                      psel_a_i,       // periph term a
    input  wire logic                      psel_b_i,       // periph term b
    input  wire logic                      mcu_rd_i,       // MCU read cycle
    input  wire logic [PW-1:0]             mcu_data_i,     // MCU data
    input  wire logic [2:0]                scan_en_i,      // scan enables
    input  wire logic [3:0]                scan_out_i,     // scan outputs
    input  wire logic [3:0]                scan_oe_i       // scan enables
);

    logic [NPORT-1:0][PW-1:0] dout_reg;
    logic [NPORT-1:0][PW-1:0] dir_reg;
    logic [NPORT-1:0][PW-1:0] drv_reg;
    logic [2:0][PW-1:0]       ctrl_reg;
    logic [15:0]              addr_lat_reg;
    logic [NPORT-1:0][PW-1:0] pin_out_reg;
    logic [NPORT-1:0][PW-1:0] pin_oe_n_reg;
    logic [NPORT-1:0][PW-1:0] logic_in_reg;
    logic [PW-1:0]            rdata_reg;
    logic                     rvalid_reg;

    logic [NPORT-1:0][PW-1:0] alt;
    logic [NPORT-1:0][PW-1:0] alt_sel;
    logic [NPORT-1:0][PW-1:0] out_c;
    logic [NPORT-1:0][PW-1:0] oe_c;
    logic [NPORT-1:0][PW-1:0] out_f;
    logic [NPORT-1:0][PW-1:0] oe_f;
    logic [2:0][PW-1:0]       icell_q;
    logic [PW-1:0]            wmask;
    logic [PW-1:0]            rd_next;
    logic [PW-1:0]            ea;
    logic [PW-1:0]            ga;
    logic [PW-1:0]            fsel_a;
    logic                     ef_ok;
    logic                     port_ok;
    logic                     ctrl_ok;
    logic [1:0]               cidx;
    logic                     periph_on;

    // port D keeps only its four low bits
    assign wmask   = (acc_i.port == PORT_D) ? PORT_D_MASK : FULL_MASK;
    assign port_ok = (acc_i.port <= PORT_G);
    assign ctrl_ok = (acc_i.port >= PORT_E) && port_ok;
    assign cidx    = 2'(acc_i.port - PORT_E);
    assign periph_on = map_reg_i[PIO_BIT];

    // writes land at the edge that takes them
    // registers clear to zero at reset
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            dout_reg <= {NPORT{REG_RST}};
        else if (acc_i.wr && port_ok && acc_i.kind == K_DOUT)
            dout_reg[acc_i.port] <= acc_i.wdata & wmask;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            dir_reg <= {NPORT{REG_RST}};
        else if (acc_i.wr && port_ok && acc_i.kind == K_DIR)
            dir_reg[acc_i.port] <= acc_i.wdata & wmask;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            drv_reg <= {NPORT{REG_RST}};
        else if (acc_i.wr && port_ok && acc_i.kind == K_DRV)
            drv_reg[acc_i.port] <= acc_i.wdata & wmask;
    end

    // only E, F and G own a control register
    // run-time modes live here, programmed ones on cfg inputs
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            ctrl_reg <= {3{REG_RST}};
        else if (acc_i.wr && ctrl_ok && acc_i.kind == K_CTRL)
            ctrl_reg[cidx] <= acc_i.wdata;
    end

    // address loaded while the strobe is high, held while it is low
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            addr_lat_reg <= 16'h0000;
        else if (addr_strobe_i)
            addr_lat_reg <= addr_i;
    end

    assign ea    = addr_lat_reg[7:0];
    assign ga    = (bus_type_i == BUS_PAGED) ? addr_lat_reg[15:8]
                                              : addr_lat_reg[7:0];
    assign ef_ok = !(bus_type_i inside {BUS_NONMUX, BUS_PAGED});

    // each cell group only on its own port; ext_sel_i on C and F, latched address on E, F and G
    // a zero control bit keeps the data register, except F pins that pld_out_cfg_i gives to ext_sel_i
    // a one control bit selects latched address, on E and F not with a non-mux or paged bus
    always_comb
    begin
        alt     = '0;
        alt_sel = '0;
        fsel_a  = ctrl_reg[1] & {PW{ef_ok}};
        alt[PORT_A]     = mcell_a_i;
        alt_sel[PORT_A] = pld_out_cfg_i[PORT_A];
        alt[PORT_B]     = mcell_b_i;
        alt_sel[PORT_B] = pld_out_cfg_i[PORT_B];
        alt[PORT_C]     = {5'h00, ext_sel_i};
        alt_sel[PORT_C] = pld_out_cfg_i[PORT_C] & ECS_PINS;
        alt[PORT_E]     = ea;
        alt_sel[PORT_E] = ctrl_reg[0] & {PW{ef_ok}};
        alt[PORT_F]     = (fsel_a & ea) | (~fsel_a & {5'h00, ext_sel_i});
        alt_sel[PORT_F] = fsel_a | (pld_out_cfg_i[PORT_F] & ECS_PINS);
        alt[PORT_G]     = ga;
        alt_sel[PORT_G] = ctrl_reg[2];
    end

    // logic outputs tri-state unless term or direction
    // a logic input relies on software keeping direction clear
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        pin_drive_cell u_drive (
            .dout_i    (dout_reg[p]),
            .alt_i     (alt[p]),
            .alt_sel_i (alt_sel[p]),
            .dir_i     (dir_reg[p]),
            .pt_oe_i   (pt_oe_i[p]),
            .pt_def_i  (pt_def_cfg_i[p]),
            .out_o     (out_c[p]),
            .oe_o      (oe_c[p])
        );
    end

    // Port-wide takeovers come last so they win over per-pin settings.
    always_comb
    begin
        out_f = out_c;
        oe_f  = oe_c;
        oe_f[PORT_D] = oe_c[PORT_D] & PORT_D_MASK;
        // any scan enable takes the low pins of E
        if (|scan_en_i)
        begin
            out_f[PORT_E] = (out_c[PORT_E] & ~SCAN_PINS)
                          | ({4'h0, scan_out_i} & SCAN_PINS);
            oe_f[PORT_E]  = (oe_c[PORT_E] & ~SCAN_PINS)
                          | ({4'h0, scan_oe_i} & SCAN_PINS);
        end
        // data port replaces every port F function
        if (data_port_cfg_i)
        begin
            out_f[PORT_F] = mcu_data_i;
            oe_f[PORT_F]  = {PW{mcu_rd_i}};
        end
        // peripheral buffer drives only on a select write
        else if (periph_on)
        begin
            out_f[PORT_F] = mcu_data_i;
            oe_f[PORT_F]  = {PW{(psel_a_i | psel_b_i) & ~mcu_rd_i}};
        end
    end

    // registered pin drive, inputs after reset
    always_ff @(posedge clk_i)
    begin
        pin_out_reg  <= resetn_i ? out_f : {NPORT{REG_RST}};
        pin_oe_n_reg <= resetn_i ? ~oe_f : {NPORT{FULL_MASK}};
    end

    for (genvar c = 0; c < 3; c++)
    begin : g_icell
        input_latch_cell u_icell (
            .clk_i    (clk_i),
            .resetn_i (resetn_i),
            .mode_i   (imc_mode_i[c]),
            .strobe_i (addr_strobe_i),
            .pt_clk_i (imc_pt_clk_i[c]),
            .use_pt_i (imc_use_pt_i[c]),
            .din_i    (pin_in_i[c]),
            .q_o      (icell_q[c])
        );
    end

    // logic input bus from cells and input-capable ports
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            logic_in_reg <= {NPORT{REG_RST}};
        else
            logic_in_reg <= {REG_RST, pin_in_i[PORT_F], REG_RST,
                             pin_in_i[PORT_D] & PORT_D_MASK,
                             icell_q[2], icell_q[1], icell_q[0]};
    end

    // one source chosen by the access kind
    always_comb
    begin
        rd_next = '0;
        if (port_ok)
        begin
            case (acc_i.kind)
                K_DIN:  rd_next = pin_in_i[acc_i.port];
                K_DOUT: rd_next = dout_reg[acc_i.port];
                K_DIR:  rd_next = dir_reg[acc_i.port];
                K_DRV:  rd_next = drv_reg[acc_i.port];
                K_CTRL: rd_next = ctrl_ok ? ctrl_reg[cidx] : '0;
                K_MCELL: rd_next = (acc_i.port == PORT_A) ? mcell_a_i :
                                   (acc_i.port == PORT_B) ? mcell_b_i : '0;
                K_ICELL: rd_next = (acc_i.port <= PORT_C) ?
                                   icell_q[acc_i.port[1:0]] : '0;
                default: rd_next = '0;
            endcase
        end
        rd_next = rd_next & wmask;
    end

    // read answered at the edge that takes it
    always_ff @(posedge clk_i)
    begin
        rvalid_reg <= resetn_i && acc_i.rd;
        if (!resetn_i)
            rdata_reg <= REG_RST;
        else if (acc_i.rd)
            rdata_reg <= rd_next;
    end

    assign pin_out_o   = pin_out_reg;
    assign pin_oe_n_o  = pin_oe_n_reg;
    assign drive_sel_o = drv_reg;
    assign logic_in_o  = logic_in_reg;
    assign rdata_o     = rdata_reg;
    assign rvalid_o    = rvalid_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_dir_drives;
        dir_reg[PORT_A][0] |=> !pin_oe_n_o[PORT_A][0];
    endproperty
    a_dir_drives: assert property (p_dir_drives)
        else $error("direction bit did not enable driver");
    property p_dir_alone;
        !pt_def_cfg_i[PORT_A][1] && !dir_reg[PORT_A][1]
            |=> pin_oe_n_o[PORT_A][1];
    endproperty
    a_dir_alone: assert property (p_dir_alone)
        else $error("driver on without direction or term");
    property p_reset_zero;
        disable iff (1'b0)
        !resetn_i |=> dir_reg == '0 && ctrl_reg == '0 && drv_reg == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("configuration not cleared by reset");
    property p_mcu_out;
        !ctrl_reg[2][0] && dir_reg[PORT_G][0]
            |=> pin_out_o[PORT_G][0] == $past(dout_reg[PORT_G][0]);
    endproperty
    a_mcu_out: assert property (p_mcu_out)
        else $error("pin not driven from data register");
    property p_addr_out;
        ctrl_reg[2][7] && dir_reg[PORT_G][7] && bus_type_i == BUS_MUX
            |=> !pin_oe_n_o[PORT_G][7]
                && pin_out_o[PORT_G][7] == $past(addr_lat_reg[7]);
    endproperty
    a_addr_out: assert property (p_addr_out)
        else $error("latched address not driven");
    property p_data_port;
        data_port_cfg_i && !mcu_rd_i |=> pin_oe_n_o[PORT_F] == FULL_MASK;
    endproperty
    a_data_port: assert property (p_data_port)
        else $error("port F driven outside data read");
    property p_periph_off;
        !data_port_cfg_i && periph_on && !psel_a_i && !psel_b_i
            |=> pin_oe_n_o[PORT_F] == FULL_MASK;
    endproperty
    a_periph_off: assert property (p_periph_off)
        else $error("peripheral buffer not tri-stated");
    property p_dir_read;
        acc_i.rd && acc_i.kind == K_DIR && acc_i.port == PORT_B
            |=> rvalid_o && rdata_o == $past(dir_reg[PORT_B]);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read-back wrong");
    property p_write_pin;
        acc_i.wr && acc_i.kind == K_DOUT && acc_i.port == PORT_D
            && dir_reg[PORT_D] == (FULL_MASK & PORT_D_MASK)
            && pld_out_cfg_i[PORT_D] == '0
            |=> ##1 pin_out_o[PORT_D] == ($past(acc_i.wdata, 2) & PORT_D_MASK);
    endproperty
    a_write_pin: assert property (p_write_pin)
        else $error("written data not on pins two edges later");
    property p_d_narrow;
        pin_oe_n_o[PORT_D][7:4] == 4'hF && dout_reg[PORT_D][7:4] == 4'h0;
    endproperty
    a_d_narrow: assert property (p_d_narrow)
        else $error("port D upper bits active");
    property p_scan;
        scan_en_i[1] |=> pin_oe_n_o[PORT_E][0] == !$past(scan_oe_i[0]);
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan enable did not take port E");

    c_addr_out: cover property (ctrl_reg[0] != '0 && dir_reg[PORT_E] != '0);
    c_periph: cover property (periph_on && psel_a_i && !mcu_rd_i);
    c_scan: cover property (|scan_en_i);
    c_icell_read: cover property (acc_i.rd && acc_i.kind == K_ICELL);

endmodule

// ===== verilog/io_port_pkg.sv
package io_port_pkg;

    localparam int NPORT = 7;
    localparam int PW    = 8;

    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_F = 3'h5;
    localparam logic [2:0] PORT_G = 3'h6;

    // Register kinds selected by an access; also the read-back source.
    localparam logic [2:0] K_DIN   = 3'h0;
    localparam logic [2:0] K_DOUT  = 3'h1;
    localparam logic [2:0] K_DIR   = 3'h2;
    localparam logic [2:0] K_CTRL  = 3'h3;
    localparam logic [2:0] K_DRV   = 3'h4;
    localparam logic [2:0] K_MCELL = 3'h5;
    localparam logic [2:0] K_ICELL = 3'h6;

    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [7:0] FULL_MASK   = 8'hFF;
    localparam logic [7:0] PORT_D_MASK = 8'h0F;
    localparam logic [7:0] ECS_PINS    = 8'h07;
    localparam logic [7:0] SCAN_PINS   = 8'h0F;
    localparam int         PIO_BIT     = 7;

    localparam logic [1:0] IC_DIRECT = 2'h0;
    localparam logic [1:0] IC_LATCH  = 2'h1;
    localparam logic [1:0] IC_REG    = 2'h2;

    localparam logic [1:0] BUS_MUX    = 2'h0;
    localparam logic [1:0] BUS_NONMUX = 2'h1;
    localparam logic [1:0] BUS_PAGED  = 2'h2;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] port;
        logic [2:0] kind;
        logic [7:0] wdata;
    } acc_t;

endpackage

// ===== verilog/pin_drive_cell.sv
`timescale 1ns/1ps
module pin_drive_cell
    import io_port_pkg::*;
(
    input  wire logic [PW-1:0] dout_i,    // data out register
    input  wire logic [PW-1:0] alt_i,     // alternate source per pin
    input  wire logic [PW-1:0] alt_sel_i, // alternate source selected
    input  wire logic [PW-1:0] dir_i,     // direction register
    input  wire logic [PW-1:0] pt_oe_i,   // enable product terms
    input  wire logic [PW-1:0] pt_def_i,  // product term defined
    output logic      [PW-1:0] out_o,     // pin output value
    output logic      [PW-1:0] oe_o       // driver enable, high drives
);

    for (genvar i = 0; i < PW; i++)
    begin : g_bit
        assign out_o[i] = alt_sel_i[i] ? alt_i[i] : dout_i[i];
        // enable is OR of term and direction
        assign oe_o[i] = (pt_def_i[i] & pt_oe_i[i]) | dir_i[i];
    end

endmodule
